// [inc/rsg_regs.vh]
// constants shared by the security state guard for error records
`ifndef RSG_REGS_VH
`define RSG_REGS_VH

// requester security state codes
`define RSG_ST_SEC 2'h0
`define RSG_ST_NSEC 2'h1
`define RSG_ST_ROOT 2'h2
`define RSG_ST_REALM 2'h3

// field selectors on the access port
`define RSG_SEL_ADDR 4'h0
`define RSG_SEL_MISC 4'h1
`define RSG_SEL_STATUS 4'h2
`define RSG_SEL_COUNT 4'h3
`define RSG_SEL_NODE 4'h4
`define RSG_SEL_DATA 4'h5
`define RSG_SEL_DED 4'h6
`define RSG_SEL_LOCK 4'h7
`define RSG_SEL_SIG 4'h8
`define RSG_SEL_INJ 4'h9
`define RSG_SEL_OPEN 4'ha

// detection and correction resource classes (bit positions)
`define RSG_DED_ROOT 0
`define RSG_DED_SEC 1
`define RSG_DED_REALM 2
`define RSG_DED_SHARED 3

// status field positions
`define RSG_STS_VALID 0
`define RSG_STS_AVALID 1
`define RSG_STS_INJ 2
`define RSG_STS_PT 3
`define RSG_STS_ENC 4
`define RSG_STS_SEV_LO 8

// signalling control positions
`define RSG_SIG_REC 0
`define RSG_SIG_SIG 1

// injection control positions
`define RSG_INJ_ARM 16

// reset values
`define RSG_RST_DED 4'hf
`define RSG_RST_LOCK 1'h1
`define RSG_RST_SIG 2'h3
`define RSG_RST_OPEN 1'h0

`endif

// [logic/rsg_ctrl_gate.v]
// write permission decode for guarded controls
`include "rsg_regs.vh"

module rsg_ctrl_gate (
   input wire [1:0] req_state_i,
   input wire root_lock_i,
   input wire inj_open_i,
   output wire [3:0] ded_ok_o,
   output wire lock_ok_o,
   output wire sig_ok_o,
   output wire inj_ok_o
);

   wire is_root;

   assign is_root = (req_state_i == `RSG_ST_ROOT);
   assign ded_ok_o[`RSG_DED_ROOT] = is_root;
   assign ded_ok_o[`RSG_DED_SEC] = is_root |
      (req_state_i == `RSG_ST_SEC);
   assign ded_ok_o[`RSG_DED_REALM] = is_root |
      (req_state_i == `RSG_ST_REALM);
   assign ded_ok_o[`RSG_DED_SHARED] = is_root | ~root_lock_i;
   assign lock_ok_o = is_root;
   assign sig_ok_o = is_root;
   // injection reachable by others only once root opens it
   assign inj_ok_o = is_root | inj_open_i;

endmodule // rsg_ctrl_gate

// [logic/rsg_inject.v]
// countdown fault injector, never address triggered
`include "rsg_regs.vh"

module rsg_inject (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire load_i,
   input wire arm_i,
   input wire [15:0] count_i,
   output reg fire_o
);

   reg [15:0] cnt;
   reg armed;

   // a delay count instead of an address match keeps access patterns
   // hidden from whoever sets up the injection
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt <= 16'h0000;
         armed <= 1'b0;
         fire_o <= 1'b0;
      end else begin
         fire_o <= 1'b0;
         if (load_i) begin
            cnt <= count_i;
            armed <= arm_i;
         end else if (armed) begin
            if (cnt == 16'h0000) begin
               fire_o <= 1'b1;
               armed <= 1'b0;
            end else begin
               cnt <= cnt - 16'h0001;
            end
         end
      end
   end

endmodule // rsg_inject

// [logic/rsg_guard.v]
// error record access guard sorted by requester security state
//
// Functional notes
// - non-secure reader never sees secure, realm or root confidential data.
// - secure reader never sees realm or root confidential data.
// - realm reader never sees secure or root confidential data.
// - root reader sees every record field unfiltered.
// - address, unit ids, status, counters, node id go out unfiltered.
// - register or memory content of another state is confidential.
// - encrypted content without freshness is as confidential as plaintext.
// - root-only resource checking ignores disables from all other states.
// - secure-only resource checking ignores realm and non-secure disables.
// - realm-only resource checking ignores secure and non-secure disables.
// - shared resource checking config writable only by root when locked.
// - signalling and recording controls accept writes from root only.
// - error consumed by protection table read raises error exception.
// - protection table fetch errors report synchronously as check faults.
// - injected faults never expose an accessed address.
// - no injection triggered by access to a chosen address.
// - injection never corrupts stored memory data.
// - records stay readable by all states, sanitised per requester.
// - mixed-space records return content by requester security state.
`include "rsg_regs.vh"

module rsg_guard #(
   // arbitrary value
   parameter [15:0] NODE_ID = 16'h0001
) (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire req_valid_i,
   input wire req_write_i,
   input wire [1:0] req_state_i,
   input wire [3:0] req_sel_i,
   input wire [31:0] req_wdata_i,
   input wire err_valid_i,
   input wire [1:0] err_owner_i,
   input wire [31:0] err_addr_i,
   input wire [31:0] err_data_i,
   input wire err_enc_i,
   input wire [15:0] err_fru_i,
   input wire [7:0] err_sev_i,
   input wire pt_fetch_err_i,
   input wire [31:0] pt_addr_i,
   output reg rd_valid_o,
   output reg [31:0] rd_data_o,
   output reg wr_ack_o,
   output reg [3:0] ded_en_o,
   output reg err_signal_o,
   output reg pt_check_fault_o,
   output reg err_exc_o
);

   // -----------------------------------------------------------------
   // visibility decode
   // -----------------------------------------------------------------
   // owner content is visible to root, to its own state, and to all
   // when the owner is non-secure
   function may_see;
      input [1:0] req;
      input [1:0] owner;
      begin
         if (req == `RSG_ST_ROOT)
            may_see = 1'b1;
         else if (owner == `RSG_ST_NSEC)
            may_see = 1'b1;
         else
            may_see = (req == owner);
      end
   endfunction

   function sel_is;
      input [3:0] sel;
      input [3:0] code;
      begin
         sel_is = (sel == code);
      end
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   reg rec_valid;
   reg rec_avalid;
   reg rec_inj;
   reg rec_pt;
   reg rec_enc;
   reg [1:0] rec_owner;
   reg [31:0] rec_addr;
   reg [31:0] rec_data;
   reg [15:0] rec_fru;
   reg [7:0] rec_sev;
   reg [15:0] rec_count;
   reg root_lock;
   reg [1:0] sig_ctl;
   reg inj_open;
   reg [31:0] next_rd_data;

   wire [3:0] ded_ok;
   wire lock_ok;
   wire sig_ok;
   wire inj_ok;
   wire inj_fire;
   wire wr;
   wire rd;
   wire data_vis;
   wire new_err;
   wire [3:0] next_ded;
   wire wr_ded;
   wire wr_lock;
   wire wr_sig;
   wire wr_open;
   wire wr_clr;
   wire wr_cnt;
   wire wr_inj;

   assign wr = req_valid_i & req_write_i;
   assign rd = req_valid_i & ~req_write_i;
   // encrypted content keeps its owner, so it filters like plaintext
   assign data_vis = may_see(req_state_i, rec_owner);
   assign new_err = err_valid_i | pt_fetch_err_i | inj_fire;

   // -----------------------------------------------------------------
   // guarded write strobes
   // -----------------------------------------------------------------
   // a blocked write never raises its strobe, except wr_ded, which every state raises and next_ded masks per class
   assign wr_ded = wr & sel_is(req_sel_i, `RSG_SEL_DED);
   assign wr_lock = wr & sel_is(req_sel_i, `RSG_SEL_LOCK) & lock_ok;
   assign wr_sig = wr & sel_is(req_sel_i, `RSG_SEL_SIG) & sig_ok;
   assign wr_open = wr & sel_is(req_sel_i, `RSG_SEL_OPEN) & lock_ok;
   assign wr_clr = wr & sel_is(req_sel_i, `RSG_SEL_STATUS) & sig_ok;
   assign wr_cnt = wr & sel_is(req_sel_i, `RSG_SEL_COUNT) & sig_ok;
   assign wr_inj = wr & sel_is(req_sel_i, `RSG_SEL_INJ) & inj_ok;

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   rsg_ctrl_gate u_gate (
      .req_state_i(req_state_i),
      .root_lock_i(root_lock),
      .inj_open_i(inj_open),
      .ded_ok_o(ded_ok),
      .lock_ok_o(lock_ok),
      .sig_ok_o(sig_ok),
      .inj_ok_o(inj_ok)
   );

   // the injector only raises an event; memory contents are untouched
   rsg_inject u_inj (
      .sys_clk_i(sys_clk_i),
      .resetn_i(resetn_i),
      .load_i(wr_inj),
      .arm_i(req_wdata_i[`RSG_INJ_ARM]),
      .count_i(req_wdata_i[15:0]),
      .fire_o(inj_fire)
   );

   // -----------------------------------------------------------------
   // read path
   // -----------------------------------------------------------------
   always @* begin
      next_rd_data = 32'h00000000;
      case (req_sel_i)
         `RSG_SEL_ADDR: next_rd_data = rec_addr;
         `RSG_SEL_MISC: next_rd_data = {16'h0000, rec_fru};
         `RSG_SEL_STATUS: begin
            next_rd_data[`RSG_STS_VALID] = rec_valid;
            next_rd_data[`RSG_STS_AVALID] = rec_avalid;
            next_rd_data[`RSG_STS_INJ] = rec_inj;
            next_rd_data[`RSG_STS_PT] = rec_pt;
            next_rd_data[`RSG_STS_ENC] = rec_enc;
            next_rd_data[`RSG_STS_SEV_LO+7:`RSG_STS_SEV_LO] = rec_sev;
         end
         `RSG_SEL_COUNT: next_rd_data = {16'h0000, rec_count};
         `RSG_SEL_NODE: next_rd_data = {16'h0000, NODE_ID};
         // confidential fields read as zero when hidden
         `RSG_SEL_DATA:
            next_rd_data = data_vis ? rec_data : 32'h00000000;
         `RSG_SEL_DED: next_rd_data = {28'h0000000, ded_en_o};
         `RSG_SEL_LOCK: next_rd_data = {31'h00000000, root_lock};
         `RSG_SEL_SIG: next_rd_data = {30'h00000000, sig_ctl};
         `RSG_SEL_OPEN: next_rd_data = {31'h00000000, inj_open};
         default: next_rd_data = 32'h00000000;
      endcase
   end

   // no state gate on reads: every state reaches the record, sanitised
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_valid_o <= 1'b0;
         rd_data_o <= 32'h00000000;
         wr_ack_o <= 1'b0;
      end else begin
         rd_valid_o <= rd;
         rd_data_o <= rd ? next_rd_data : 32'h00000000;
         // blocked writes are acknowledged like any other
         wr_ack_o <= wr;
      end
   end

   // -----------------------------------------------------------------
   // detection and correction enables
   // -----------------------------------------------------------------
   // an untrusted writer may turn checking on but never off
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_ded
         assign next_ded[gi] = ded_ok[gi] ? req_wdata_i[gi] :
            (ded_en_o[gi] | req_wdata_i[gi]);
      end
   endgenerate

   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ded_en_o <= `RSG_RST_DED;
         root_lock <= `RSG_RST_LOCK;
         sig_ctl <= `RSG_RST_SIG;
         inj_open <= `RSG_RST_OPEN;
      end else if (wr) begin
         if (wr_ded)
            ded_en_o <= next_ded;
         if (wr_lock)
            root_lock <= req_wdata_i[0];
         if (wr_sig)
            sig_ctl <= req_wdata_i[1:0];
         if (wr_open)
            inj_open <= req_wdata_i[0];
      end
   end

   // -----------------------------------------------------------------
   // record capture
   // -----------------------------------------------------------------
   // priority: table fetch error, then logged error, then injection.
   // a capture in the same cycle as a root clear wins over the clear.
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rec_valid <= 1'b0;
         rec_avalid <= 1'b0;
         rec_inj <= 1'b0;
         rec_pt <= 1'b0;
         rec_enc <= 1'b0;
         rec_owner <= `RSG_ST_ROOT;
         rec_addr <= 32'h00000000;
         rec_data <= 32'h00000000;
         rec_fru <= 16'h0000;
         rec_sev <= 8'h00;
         rec_count <= 16'h0000;
      end else if (new_err & sig_ctl[`RSG_SIG_REC]) begin
         rec_valid <= 1'b1;
         rec_count <= rec_count + 16'h0001;
         if (pt_fetch_err_i) begin
            rec_pt <= 1'b1;
            rec_inj <= 1'b0;
            rec_enc <= 1'b0;
            rec_avalid <= 1'b1;
            rec_owner <= `RSG_ST_ROOT;
            rec_addr <= pt_addr_i;
            rec_data <= 32'h00000000;
         end else if (err_valid_i) begin
            rec_pt <= 1'b0;
            rec_inj <= 1'b0;
            rec_enc <= err_enc_i;
            rec_avalid <= 1'b1;
            rec_owner <= err_owner_i;
            rec_addr <= err_addr_i;
            rec_data <= err_data_i;
            rec_fru <= err_fru_i;
            rec_sev <= err_sev_i;
         end else begin
            // address held and marked invalid so no access leaks out
            rec_inj <= 1'b1;
            rec_pt <= 1'b0;
            rec_avalid <= 1'b0;
            rec_data <= 32'h00000000;
         end
      end else if (wr_clr) begin
         if (req_wdata_i[`RSG_STS_VALID])
            rec_valid <= 1'b0;
      end else if (wr_cnt) begin
         rec_count <= req_wdata_i[15:0];
      end
   end

   // -----------------------------------------------------------------
   // error signalling
   // -----------------------------------------------------------------
   // table fetch errors always go back synchronously as a check fault,
   // independent of the signalling enable
   always @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         err_signal_o <= 1'b0;
         pt_check_fault_o <= 1'b0;
         err_exc_o <= 1'b0;
      end else begin
         err_signal_o <= new_err & sig_ctl[`RSG_SIG_SIG];
         pt_check_fault_o <= pt_fetch_err_i;
         err_exc_o <= pt_fetch_err_i;
      end
   end

endmodule // rsg_guard

// [bench/rsg_guard_monitor.sv]
// port checker for the error record security guard
`include "rsg_regs.vh"

module rsg_guard_monitor (
   input wire sys_clk_i,
   input wire resetn_i,
   input wire req_valid_i,
   input wire req_write_i,
   input wire [1:0] req_state_i,
   input wire [3:0] req_sel_i,
   input wire pt_fetch_err_i,
   input wire rd_valid_o,
   input wire [31:0] rd_data_o,
   input wire wr_ack_o,
   input wire [3:0] ded_en_o,
   input wire pt_check_fault_o,
   input wire err_exc_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!resetn_i);
   wire ded_wr = req_valid_i && req_write_i && req_sel_i == `RSG_SEL_DED;
   wire by_root = ded_wr && req_state_i == `RSG_ST_ROOT;
   wire by_sec = ded_wr && req_state_i == `RSG_ST_SEC;
   wire by_realm = ded_wr && req_state_i == `RSG_ST_REALM;
   // -------------------------------------------
   // answers and guarded enables
   // -------------------------------------------
   a_read_answer: assert property (req_valid_i && !req_write_i |=> rd_valid_o && !wr_ack_o)
      else $error("read not answered");
   a_write_ack: assert property (req_valid_i && req_write_i |=> wr_ack_o && !rd_valid_o)
      else $error("write not acknowledged");
   a_idle_zero: assert property (!rd_valid_o |-> rd_data_o == 32'h0)
      else $error("read data outside answer");
   a_pt_sync: assert property (pt_fetch_err_i |=> pt_check_fault_o && err_exc_o)
      else $error("table fetch error not reported");
   a_pt_cause: assert property (pt_check_fault_o || err_exc_o |-> $past(pt_fetch_err_i))
      else $error("spurious check fault");
   a_root_keep: assert property ($fell(ded_en_o[0]) |-> $past(by_root))
      else $error("root class disabled by other state");
   a_sec_keep: assert property ($fell(ded_en_o[1]) |-> $past(by_root) || $past(by_sec))
      else $error("secure class disabled by other state");
   a_realm_keep: assert property ($fell(ded_en_o[2]) |-> $past(by_root) || $past(by_realm))
      else $error("realm class disabled by other state");
   a_ded_still: assert property (!ded_wr |=> $stable(ded_en_o))
      else $error("enables moved without write");
   c_pt: cover property (pt_fetch_err_i);
   c_data: cover property (rd_valid_o && rd_data_o != 32'h0);
   c_shared: cover property ($fell(ded_en_o[3]));
endmodule // rsg_guard_monitor

bind rsg_guard rsg_guard_monitor i_rsg_guard_monitor (.sys_clk_i, .resetn_i,
   .req_valid_i, .req_write_i, .req_state_i, .req_sel_i, .pt_fetch_err_i,
   .rd_valid_o, .rd_data_o, .wr_ack_o, .ded_en_o, .pt_check_fault_o,
   .err_exc_o);

// [bench/rsg_err_source.sv]
// behavioural source of error reports and table fetch errors
module rsg_err_source (
   input wire sys_clk_i,
   output logic err_valid_o,
   output logic [1:0] err_owner_o,
   output logic [31:0] err_addr_o,
   output logic [31:0] err_data_o,
   output logic err_enc_o,
   output wire [15:0] err_fru_o,
   output wire [7:0] err_sev_o,
   output logic pt_fetch_err_o,
   output wire [31:0] pt_addr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic busy = 1'h0;
   // unit id and severity ride on the address and data lines
   assign err_fru_o = err_addr_o[15:0];
   assign err_sev_o = err_data_o[7:0];
   assign pt_addr_o = err_addr_o;
   initial begin
      {err_valid_o, pt_fetch_err_o, err_enc_o, err_owner_o} = 5'h0;
      err_addr_o = 32'h0;
      err_data_o = 32'h0;
   end
   // ---------------------------------
   // idle address and data lines invert on every clock
   // ---------------------------------
   always @(posedge sys_clk_i) begin
      if (!busy) begin
         err_addr_o <= ~err_addr_o;
         err_data_o <= ~err_data_o;
      end
   end
   task automatic send(input logic pt, input logic [1:0] ow,
                       input logic [31:0] ad, input logic [31:0] dt);
      busy = 1'h1;
      err_owner_o = ow;
      err_addr_o = ad;
      err_data_o = dt;
      err_enc_o = dt[0];
      err_valid_o = !pt;
      pt_fetch_err_o = pt;
      @(negedge sys_clk_i);
      {err_valid_o, pt_fetch_err_o} = 2'h0;
      busy = 1'h0;
   endtask
endmodule // rsg_err_source

// [bench/testbench.sv]
// self-checking bench for the error record security guard
`include "rsg_regs.vh"
`define CHK(nm, got, exp) \
   total_checks++; \
   if ((got) !== (exp)) begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
   end

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam [1:0] NS = `RSG_ST_NSEC;
   localparam [1:0] RT = `RSG_ST_ROOT;
   // node id value is arbitrary
   localparam [15:0] NID = 16'h5a3c;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic rqv = 1'h0;
   logic rqw = 1'h0;
   logic [1:0] rqs = 2'h0;
   logic [3:0] rqsel = 4'h0;
   logic [31:0] rqd = 32'h0;
   logic [15:0] seed = 16'hf59c;
   logic [31:0] d, rdv, ea, pa;
   int err_total = 0;
   int total_checks = 0;
   int cnt = 0;
   int i, j, k;
   wire ev, een, pte, rvd, wak, esig, ptf, exc;
   wire [1:0] eow;
   wire [31:0] ead, edt, pad, rdd;
   wire [15:0] efru;
   wire [7:0] esev;
   wire [3:0] ded;

   rsg_err_source i_rsg_err_source (.sys_clk_i(clk), .err_valid_o(ev),
      .err_owner_o(eow), .err_addr_o(ead), .err_data_o(edt),
      .err_enc_o(een), .err_fru_o(efru), .err_sev_o(esev),
      .pt_fetch_err_o(pte), .pt_addr_o(pad));
   rsg_guard #(.NODE_ID(NID)) i_rsg_guard (.sys_clk_i(clk), .resetn_i(rstn),
      .req_valid_i(rqv), .req_write_i(rqw), .req_state_i(rqs),
      .req_sel_i(rqsel), .req_wdata_i(rqd), .err_valid_i(ev),
      .err_owner_i(eow), .err_addr_i(ead), .err_data_i(edt),
      .err_enc_i(een), .err_fru_i(efru), .err_sev_i(esev),
      .pt_fetch_err_i(pte), .pt_addr_i(pad), .rd_valid_o(rvd),
      .rd_data_o(rdd), .wr_ack_o(wak), .ded_en_o(ded),
      .err_signal_o(esig), .pt_check_fault_o(ptf), .err_exc_o(exc));

   function automatic logic [15:0] lfsr(input logic [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [31:0] exp_data(input logic [1:0] rq, ow,
                                            input logic [31:0] dt);
      exp_data = (rq == RT || ow == NS || rq == ow) ? dt : 32'h0;
   endfunction
   // bits left set after a clear-all write by state s
   function automatic logic [3:0] exp_ded(input logic [1:0] s);
      exp_ded[0] = s != RT;
      exp_ded[1] = !(s == RT || s == `RSG_ST_SEC);
      exp_ded[2] = !(s == RT || s == `RSG_ST_REALM);
      exp_ded[3] = s != RT;
   endfunction
   // request held high when called back to back; idle drops it
   task automatic acc(input logic w, input logic [1:0] s,
                      input logic [3:0] sl, input logic [31:0] wd);
      rqv = 1'h1;
      rqw = w;
      rqs = s;
      rqsel = sl;
      rqd = wd;
      @(negedge clk);
      rdv = rdd;
      `CHK("answer", w ? wak : rvd, 1'h1)
   endtask
   task automatic idle;
      rqv = 1'h0;
      @(negedge clk);
   endtask
   task results;
      if (err_total == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      forever #5 clk = ~clk;
   end
   initial begin
      #200us;
      err_total++;
      results;
   end
   // -----------------------------
   // main sequence
   // -----------------------------
   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rstn = 1'h1;
      `CHK("ded reset", ded, 4'hf)
      for (i = 0; i < 4; i++) begin
         if (i[1:0] != RT) acc(1'h1, i[1:0], `RSG_SEL_SIG, 32'h0);
      end
      idle;
      for (i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         d = {seed, ~seed};
         ea = {~seed, seed};
         i_rsg_err_source.send(1'h0, i[3:2], ea, d);
         cnt++;
         `CHK("signal", esig, 1'h1)
         acc(1'h0, i[1:0], `RSG_SEL_DATA, 32'h0);
         `CHK("data", rdv, exp_data(i[1:0], i[3:2], d))
         acc(1'h0, i[1:0], `RSG_SEL_ADDR, 32'h0);
         `CHK("addr", rdv, ea)
         acc(1'h0, i[1:0], `RSG_SEL_STATUS, 32'h0);
         `CHK("status", rdv, {16'h0, d[7:0], 3'h0, d[0], 4'h3})
         acc(1'h0, i[1:0], `RSG_SEL_COUNT, 32'h0);
         `CHK("count", rdv, 32'(cnt))
         acc(1'h0, i[1:0], `RSG_SEL_MISC, 32'h0);
         `CHK("misc", rdv, {16'h0, ea[15:0]})
         acc(1'h0, i[1:0], `RSG_SEL_NODE, 32'h0);
         `CHK("node", rdv, {16'h0, NID})
         idle;
      end
      for (i = 0; i < 4; i++) begin
         acc(1'h1, i[1:0], `RSG_SEL_DED, 32'h0);
         `CHK("ded", ded, exp_ded(i[1:0]))
         acc(1'h1, RT, `RSG_SEL_DED, 32'hf);
      end
      acc(1'h1, RT, `RSG_SEL_LOCK, 32'h0);
      acc(1'h1, NS, `RSG_SEL_LOCK, 32'h1);
      acc(1'h1, NS, `RSG_SEL_DED, 32'h7);
      `CHK("shared", ded, 4'h7)
      acc(1'h0, RT, `RSG_SEL_DED, 32'h0);
      `CHK("ded read", rdv, 32'h7)
      acc(1'h1, RT, `RSG_SEL_SIG, 32'h0);
      idle;
      i_rsg_err_source.send(1'h0, NS, ea, d);
      `CHK("muted", esig, 1'h0)
      acc(1'h1, RT, `RSG_SEL_SIG, 32'h3);
      acc(1'h0, RT, `RSG_SEL_COUNT, 32'h0);
      `CHK("no record", rdv, 32'(cnt))
      idle;
      pa = {lfsr(seed), 16'h0};
      i_rsg_err_source.send(1'h1, RT, pa, 32'h0);
      cnt++;
      `CHK("check fault", ptf, 1'h1)
      `CHK("exception", exc, 1'h1)
      acc(1'h0, NS, `RSG_SEL_ADDR, 32'h0);
      `CHK("pt addr", rdv, pa)
      acc(1'h1, NS, `RSG_SEL_INJ, 32'h10002);
      idle;
      repeat (6) @(negedge clk);
      acc(1'h0, NS, `RSG_SEL_COUNT, 32'h0);
      `CHK("inj blocked", rdv, 32'(cnt))
      acc(1'h1, RT, `RSG_SEL_OPEN, 32'h1);
      acc(1'h1, NS, `RSG_SEL_INJ, 32'h10002);
      idle;
      for (k = 0; k < 20 && esig !== 1'h1; k++) @(negedge clk);
      `CHK("inj fired", esig, 1'h1)
      if (k == 20) results;
      cnt++;
      acc(1'h0, NS, `RSG_SEL_STATUS, 32'h0);
      `CHK("inj status", rdv[2:1], 2'h2)
      acc(1'h0, NS, `RSG_SEL_ADDR, 32'h0);
      `CHK("inj addr", rdv, pa)
      acc(1'h0, RT, `RSG_SEL_DATA, 32'h0);
      `CHK("inj data", rdv, 32'h0)
      acc(1'h1, NS, `RSG_SEL_COUNT, 32'h0);
      acc(1'h0, NS, `RSG_SEL_COUNT, 32'h0);
      `CHK("cnt blocked", rdv, 32'(cnt))
      acc(1'h1, NS, `RSG_SEL_STATUS, 32'h1);
      acc(1'h0, NS, `RSG_SEL_STATUS, 32'h0);
      `CHK("clr blocked", rdv[0], 1'h1)
      acc(1'h1, RT, `RSG_SEL_STATUS, 32'h1);
      acc(1'h0, RT, `RSG_SEL_STATUS, 32'h0);
      `CHK("clr root", rdv[0], 1'h0)
      acc(1'h1, RT, `RSG_SEL_COUNT, 32'h5);
      acc(1'h0, NS, `RSG_SEL_COUNT, 32'h0);
      `CHK("cnt root", rdv, 32'h5)
      idle;
      results;
   end
endmodule // testbench
